// >>> core/cdru_consts.svh
// Constants for the configuration loader with decompression and remote update.
// Included by the design module and the testbench; definitions only.
`ifndef CDRU_CONSTS_SVH
`define CDRU_CONSTS_SVH
`define CDRU_FACTORY_ADDR   24'h000000
`define CDRU_SCHEME_AS      5'h12
`define CDRU_SCHEME_PS      5'h10
`define CDRU_SCHEME_FPP     5'h00
`define CDRU_SCHEME_JTAG    5'h1f
`define CDRU_RATIO_PLAIN    3'h1
`define CDRU_RATIO_COMP     3'h4
`define CDRU_CAUSE_NONE     3'h0
`define CDRU_CAUSE_STATUS   3'h1
`define CDRU_CAUSE_CRC      3'h2
`define CDRU_CAUSE_WDOG     3'h3
`define CDRU_CAUSE_CORE     3'h4
`define CDRU_CAUSE_EXT      3'h5
`define CDRU_WDOG_DEFAULT   16'hffff
`endif

// >>> core/cdru_pkg.sv
// Types shared by the configuration loader.
// Constants live in cdru_consts.svh.
package cdru_pkg;
   typedef enum logic [1:0]
   {
      CDRU_ST_IDLE = 2'b00,
      CDRU_ST_LOAD = 2'b01,
      CDRU_ST_USER = 2'b10,
      CDRU_ST_ERR  = 2'b11
   } cdru_state_t;
endpackage

// >>> core/cdru_fifo.sv
// Synchronous FIFO between decompressor and cell write.
// Single clock; valid/ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module cdru_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)(
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed
   {
      logic [AW:0]   wr;
      logic [AW:0]   rd;
   } cdru_fifo_st_t;
   cdru_fifo_st_t       st_reg;
   cdru_fifo_st_t       st_next;
   logic [WIDTH-1:0]    mem [DEPTH];
   logic                push;
   logic                pop;

   // Full when pointers differ only in wrap bit
   assign o_in_ready  = !((st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]));
   assign o_out_valid = (st_reg.wr != st_reg.rd);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[st_reg.rd[AW-1:0]];

   // Pointer update
   always_comb
   begin
      st_next = st_reg;
      if (push)
         st_next.wr = st_reg.wr + 1'b1;
      if (pop)
         st_next.rd = st_reg.rd + 1'b1;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Storage has no reset; content is guarded by pointers
   always_ff @(posedge i_mclk)
   begin
      if (push)
         mem[st_reg.wr[AW-1:0]] <= i_in_data;
   end
endmodule // cdru_fifo
`default_nettype wire

// >>> core/cdru_loader.sv
// Configuration loader: link-side word intake, decompression, image fetch
// control and fallback on error. Assumes the link clock is driven by the
// partner only during frames and that i_mclk runs freely.
`timescale 1ns/100ps
`default_nettype none
`include "cdru_consts.svh"
module cdru_loader #(
   parameter int FIFO_DEPTH = 8,
   parameter int WDOG_W     = 16
)(
   // System clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Link side, clocked by config_clock_pin
   input  wire logic        i_config_clock_pin,
   input  wire logic [7:0]  i_link_data,
   input  wire logic        i_link_valid,
   // Straps and per-device setting
   input  wire logic [4:0]  i_scheme_select_pins,
   input  wire logic        i_compress_en,
   // External pins
   input  wire logic        i_status_error_pin_n,
   input  wire logic        i_reconfig_request_pin_n,
   input  wire logic        i_crc_error,
   // Core requests
   input  wire logic        i_core_reconfig,
   input  wire logic [23:0] i_next_image_start_address,
   input  wire logic        i_wdog_en,
   input  wire logic        i_wdog_kick,
   input  wire logic        i_load_done,
   // Flash fetch
   output logic             o_fetch_start,
   output logic [23:0]      o_image_start_address,
   // Cell write stream
   output logic             o_cell_valid,
   output logic [7:0]       o_cell_data,
   input  wire logic        i_cell_ready,
   // Status
   output logic [2:0]       o_cause,
   output logic             o_factory_active,
   output logic             o_remote_ok,
   output logic [2:0]       o_clocks_per_word,
   output logic             o_link_busy,
   output logic             o_user_mode
);
   // Link domain: gray write pointer into small async buffer
   localparam int LAW = 2;
   logic [7:0]     link_mem [4];
   logic [LAW:0]   lwr_bin_reg;
   logic [LAW:0]   lwr_gray_reg;
   logic [LAW:0]   lrd_gray_s1_reg;
   logic [LAW:0]   lrd_gray_s2_reg;
   logic [LAW:0]   lrd_gray_m_reg;
   logic [LAW:0]   lrd_gray_full;
   logic           link_push;

   // Gray full test against synchronised read pointer
   assign lrd_gray_full = {~lrd_gray_s2_reg[LAW:LAW-1], lrd_gray_s2_reg[LAW-2:0]};
   assign o_link_busy   = 1'b0;
   assign link_push     = i_link_valid && (lwr_gray_reg != lrd_gray_full);

   always_ff @(posedge i_config_clock_pin or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lwr_bin_reg     <= '0;
         lwr_gray_reg    <= '0;
         lrd_gray_s1_reg <= '0;
         lrd_gray_s2_reg <= '0;
      end
      else
      begin
         lrd_gray_s1_reg <= lrd_gray_m_reg;
         lrd_gray_s2_reg <= lrd_gray_s1_reg;
         if (link_push)
         begin
            lwr_bin_reg  <= lwr_bin_reg + 1'b1;
            lwr_gray_reg <= (lwr_bin_reg + 1'b1) ^ ((lwr_bin_reg + 1'b1) >> 1);
         end
      end
   end

   always_ff @(posedge i_config_clock_pin)
   begin
      if (link_push)
         link_mem[lwr_bin_reg[LAW-1:0]] <= i_link_data;
   end

   // System domain state
   typedef struct packed
   {
      cdru_pkg::cdru_state_t  state;
      logic [LAW:0]           rd_bin;
      logic [LAW:0]           wr_s1;
      logic [LAW:0]           wr_s2;
      logic [4:0]             sel_s1;
      logic [4:0]             sel_s2;
      logic [2:0]             pin_s1;
      logic [2:0]             pin_s2;
      logic                   ext_prev;
      logic                   factory;
      logic [2:0]             cause;
      logic [23:0]            addr;
      logic                   fetch;
      logic [7:0]             run_byte;
      logic [3:0]             run_cnt;
      logic [1:0]             dec_ph;
      logic [WDOG_W-1:0]      wdog;
   } cdru_st_t;
   cdru_st_t       st_reg;
   cdru_st_t       st_next;
   logic [LAW:0]   rd_gray;
   logic           buf_valid;
   logic [7:0]     buf_data;
   logic           buf_pop;
   logic           dec_valid;
   logic [7:0]     dec_data;
   logic           fifo_ready;
   logic           is_as;
   logic           is_jtag;
   logic           comp;
   logic           ext_req;

   assign rd_gray   = st_reg.rd_bin ^ (st_reg.rd_bin >> 1);
   assign buf_valid = (rd_gray != st_reg.wr_s2);
   assign buf_data  = link_mem[st_reg.rd_bin[LAW-1:0]];
   assign is_as     = (st_reg.sel_s2 == `CDRU_SCHEME_AS);
   assign is_jtag   = (st_reg.sel_s2 == `CDRU_SCHEME_JTAG);
   assign comp      = i_compress_en && !is_jtag;
   assign ext_req   = st_reg.pin_s2[1] && !st_reg.ext_prev; // Low-to-high starts reconfig

   // Read pointer published as gray from a flop
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         lrd_gray_m_reg <= '0;
      else
         lrd_gray_m_reg <= rd_gray;
   end

   // Decompressor: byte 0 = literal; with compression a byte with top bit set is
   // a run header (count in low nibble) followed by the byte to repeat
   always_comb
   begin
      dec_valid = 1'b0;
      dec_data  = buf_data;
      buf_pop   = 1'b0;
      if (st_reg.run_cnt != 4'h0 && st_reg.dec_ph == 2'h0) // Run repeats its stored value byte
      begin
         dec_valid = 1'b1;
         dec_data  = st_reg.run_byte;
      end
      else if (buf_valid && st_reg.state == cdru_pkg::CDRU_ST_LOAD)
      begin
         if (comp && st_reg.dec_ph == 2'h0 && buf_data[7])
            buf_pop = 1'b1;
         else if (comp && st_reg.dec_ph == 2'h1)
            buf_pop = 1'b1;
         else
         begin
            dec_valid = 1'b1;
            buf_pop   = fifo_ready;
         end
      end
   end

   // Main control
   always_comb
   begin
      st_next        = st_reg;
      st_next.wr_s1  = lwr_gray_reg;
      st_next.wr_s2  = st_reg.wr_s1;
      st_next.sel_s1 = i_scheme_select_pins;
      st_next.sel_s2 = st_reg.sel_s1;
      st_next.pin_s1 = {i_crc_error, i_reconfig_request_pin_n, i_status_error_pin_n};
      st_next.pin_s2 = st_reg.pin_s1;
      st_next.ext_prev = st_reg.pin_s2[1];
      st_next.fetch  = 1'b0;
      if (buf_pop)
         st_next.rd_bin = st_reg.rd_bin + 1'b1;
      // Run expansion
      if (st_reg.run_cnt != 4'h0 && st_reg.dec_ph == 2'h0 && fifo_ready)
         st_next.run_cnt = st_reg.run_cnt - 1'b1;
      else if (buf_pop && comp && st_reg.dec_ph == 2'h0 && buf_data[7])
      begin
         st_next.run_cnt = buf_data[3:0];
         st_next.dec_ph  = 2'h1;
      end
      else if (buf_pop && st_reg.dec_ph == 2'h1)
      begin
         st_next.run_byte = buf_data;
         st_next.dec_ph   = 2'h0;
      end
      unique case (st_reg.state)
         cdru_pkg::CDRU_ST_IDLE:
         begin
            // Power-up: factory image at address zero
            st_next.factory = 1'b1;
            st_next.addr    = `CDRU_FACTORY_ADDR;
            st_next.fetch   = 1'b1;
            st_next.state   = cdru_pkg::CDRU_ST_LOAD;
         end
         cdru_pkg::CDRU_ST_LOAD:
         begin
            if (!st_reg.pin_s2[0] || st_reg.pin_s2[2])
               st_next.state = cdru_pkg::CDRU_ST_ERR;
            else if (i_load_done)
               st_next.state = cdru_pkg::CDRU_ST_USER;
         end
         cdru_pkg::CDRU_ST_USER:
         begin
            if (i_wdog_kick)
               st_next.wdog = WDOG_W'(`CDRU_WDOG_DEFAULT);
            else if (i_wdog_en && !st_reg.factory && st_reg.wdog != '0)
               st_next.wdog = st_reg.wdog - 1'b1;
            if (!st_reg.factory && is_as)
            begin
               // Revert triggers, highest priority first
               if (!st_reg.pin_s2[0])
                  st_next.cause = `CDRU_CAUSE_STATUS;
               else if (st_reg.pin_s2[2])
                  st_next.cause = `CDRU_CAUSE_CRC;
               else if (i_wdog_en && st_reg.wdog == '0)
                  st_next.cause = `CDRU_CAUSE_WDOG;
               else if (i_core_reconfig)
                  st_next.cause = `CDRU_CAUSE_CORE;
               else if (ext_req)
                  st_next.cause = `CDRU_CAUSE_EXT;
               if (!st_reg.pin_s2[0] || st_reg.pin_s2[2] || (i_wdog_en && st_reg.wdog == '0)
                   || i_core_reconfig || ext_req)
               begin
                  st_next.factory = 1'b1;
                  st_next.addr    = `CDRU_FACTORY_ADDR;
                  st_next.fetch   = 1'b1;
                  st_next.state   = cdru_pkg::CDRU_ST_LOAD;
               end
            end
            else if (st_reg.factory && is_as && (i_core_reconfig || ext_req))
            begin
               // Factory chooses the application image
               st_next.factory = 1'b0;
               st_next.cause   = i_core_reconfig ? `CDRU_CAUSE_CORE : `CDRU_CAUSE_EXT;
               st_next.addr    = i_next_image_start_address;
               st_next.fetch   = 1'b1;
               st_next.wdog    = WDOG_W'(`CDRU_WDOG_DEFAULT);
               st_next.state   = cdru_pkg::CDRU_ST_LOAD;
            end
         end
         cdru_pkg::CDRU_ST_ERR:
         begin
            // Load failed: fall back to factory
            st_next.cause   = `CDRU_CAUSE_STATUS;
            st_next.factory = 1'b1;
            st_next.addr    = `CDRU_FACTORY_ADDR;
            st_next.fetch   = 1'b1;
            st_next.state   = cdru_pkg::CDRU_ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_reg         <= '0;
         st_reg.state   <= cdru_pkg::CDRU_ST_IDLE;
         st_reg.pin_s1  <= 3'h3;
         st_reg.pin_s2  <= 3'h3;
         st_reg.ext_prev <= 1'b1;
         st_reg.factory <= 1'b1;
         st_reg.wdog    <= WDOG_W'(`CDRU_WDOG_DEFAULT);
      end
      else
         st_reg <= st_next;
   end

   // Output FIFO toward the cells; its ready stalls the decompressor
   cdru_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_rst_n     (i_rst_n),
      .i_in_valid  (dec_valid),
      .i_in_data   (dec_data),
      .o_in_ready  (fifo_ready),
      .o_out_valid (o_cell_valid),
      .o_out_data  (o_cell_data),
      .i_out_ready (i_cell_ready)
   );

   // Status outputs
   assign o_fetch_start         = st_reg.fetch;
   assign o_image_start_address = st_reg.addr;
   assign o_cause               = st_reg.cause;
   assign o_factory_active      = st_reg.factory;
   assign o_remote_ok           = is_as;
   assign o_clocks_per_word     = (comp && st_reg.sel_s2 == `CDRU_SCHEME_FPP) ? `CDRU_RATIO_COMP : `CDRU_RATIO_PLAIN;
   assign o_user_mode           = (st_reg.state == cdru_pkg::CDRU_ST_USER);

   // Assertions
   a_powerup_factory: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $past(st_reg.state) == cdru_pkg::CDRU_ST_IDLE |-> st_reg.factory && st_reg.addr == `CDRU_FACTORY_ADDR)
      else $error("power-up did not select factory");
   a_fallback_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      st_reg.fetch && st_reg.factory |-> st_reg.addr == `CDRU_FACTORY_ADDR)
      else $error("factory fetch not at zero");
   a_err_reverts: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      st_reg.state == cdru_pkg::CDRU_ST_ERR |=> st_reg.factory && st_reg.fetch)
      else $error("error did not revert");
   a_crc_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      st_reg.state == cdru_pkg::CDRU_ST_USER && !st_reg.factory && is_as && st_reg.pin_s2 == 3'h7
      |=> st_reg.cause == `CDRU_CAUSE_CRC && st_reg.factory)
      else $error("crc cause wrong");
   a_app_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      st_reg.state == cdru_pkg::CDRU_ST_USER && st_reg.factory && is_as && i_core_reconfig
      |=> !st_reg.factory && st_reg.addr == $past(i_next_image_start_address))
      else $error("app address wrong");
   a_no_remote_off_as: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !is_as && st_reg.state == cdru_pkg::CDRU_ST_USER |=> st_reg.factory == $past(st_reg.factory))
      else $error("image switched outside active serial");
   a_jtag_plain: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      is_jtag |-> st_reg.run_cnt == 4'h0 || $past(st_reg.run_cnt) != 4'h0)
      else $error("run started under boundary scan");
   a_ratio_sel: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_clocks_per_word == `CDRU_RATIO_COMP |-> comp && st_reg.sel_s2 == `CDRU_SCHEME_FPP)
      else $error("ratio wrong");
   c_app_switch: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      st_reg.factory ##1 !st_reg.factory);
   c_revert: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      !st_reg.factory ##1 st_reg.factory);
   c_run: cover property (@(posedge i_mclk) disable iff (!i_rst_n) st_reg.run_cnt != 4'h0);
endmodule // cdru_loader
`default_nettype wire

// >>> tb/cdru_link_host.sv
// Link host model: streams configuration bytes into the loader's link port.
// Assumes the bench keeps each frame within the loader's 4-byte intake buffer.
`timescale 1ns/100ps
`default_nettype none
module cdru_link_host (
   // Link outputs
   output logic       o_config_clock_pin,
   output logic [7:0] o_link_data,
   output logic       o_link_valid
);
   // Idle link: clock parked low, data scrambled, nothing valid
   initial
   begin
      o_config_clock_pin = 1'b0;
      o_link_data        = 8'ha5;
      o_link_valid       = 1'b0;
   end

   // One frame; the 32 ns clock runs for two idle cycles, then while bytes flow
   task automatic send_frame(input logic [7:0] bytes[$]);
      // Two idle edges first: the read-pointer sync only moves while this clock runs
      o_link_valid = 1'b0;
      repeat (2)
      begin
         #16 o_config_clock_pin = 1'b1;
         #16 o_config_clock_pin = 1'b0;
      end
      for (int i = 0; i < bytes.size(); i++)
      begin
         o_link_data  = bytes[i];
         o_link_valid = 1'b1;
         #16 o_config_clock_pin = 1'b1;
         #16 o_config_clock_pin = 1'b0;
      end
      // Released data is inverted so a stale byte never looks current
      o_link_valid = 1'b0;
      o_link_data  = ~o_link_data;
   endtask
endmodule // cdru_link_host
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the configuration loader.
// Assumes cdru_loader, cdru_fifo and the link host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "cdru_consts.svh"
module testbench;
   typedef struct {logic [4:0] sch; logic cmp; int trig; logic ok; logic [2:0] cpw;} cdru_row_t;
   // Design stimulus and observation
   logic        mclk, rst_n, lclk, lvalid, comp, stat_n, ext_n, crc, core_req;
   logic        wd_en, wd_kick, ld_done, fetch, cvalid, cready, fact, rok, umode;
   logic        stall, rdy_lvl, seen;
   logic [7:0]  ldata, cdata;
   logic [4:0]  scheme;
   logic [23:0] app_addr, addr;
   logic [2:0]  cause, cpw;
   logic [7:0]  got[$];
   int          n_mismatch, cmp_count, cyc;
   cdru_row_t   rows[9] = '{
      '{`CDRU_SCHEME_AS,   1'b0, 1, 1'b1, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_AS,   1'b1, 2, 1'b1, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_PS,   1'b1, 0, 1'b0, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_FPP,  1'b1, 0, 1'b0, `CDRU_RATIO_COMP},
      '{`CDRU_SCHEME_FPP,  1'b0, 0, 1'b0, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_JTAG, 1'b1, 0, 1'b0, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_AS,   1'b0, 3, 1'b1, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_AS,   1'b1, 4, 1'b1, `CDRU_RATIO_PLAIN},
      '{`CDRU_SCHEME_AS,   1'b0, 5, 1'b1, `CDRU_RATIO_PLAIN}};

   // Small watchdog width keeps the timeout case short
   cdru_loader #(.FIFO_DEPTH(8), .WDOG_W(4)) cdru_loader_inst (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_config_clock_pin(lclk), .i_link_data(ldata),
      .i_link_valid(lvalid), .i_scheme_select_pins(scheme), .i_compress_en(comp),
      .i_status_error_pin_n(stat_n), .i_reconfig_request_pin_n(ext_n), .i_crc_error(crc),
      .i_core_reconfig(core_req), .i_next_image_start_address(app_addr), .i_wdog_en(wd_en),
      .i_wdog_kick(wd_kick), .i_load_done(ld_done), .o_fetch_start(fetch),
      .o_image_start_address(addr), .o_cell_valid(cvalid), .o_cell_data(cdata),
      .i_cell_ready(cready), .o_cause(cause), .o_factory_active(fact), .o_remote_ok(rok),
      .o_clocks_per_word(cpw), .o_link_busy(), .o_user_mode(umode));

   cdru_link_host cdru_link_host_inst (
      .o_config_clock_pin(lclk), .o_link_data(ldata), .o_link_valid(lvalid));

   // 50 ns system clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Cell-side ready: steady level or toggling stall
   always @(negedge mclk)
      cready <= stall ? ~cready : rdy_lvl;

   // Collect every accepted cell word
   always @(posedge mclk)
      if (cvalid === 1'b1 && cready === 1'b1)
         got.push_back(cdata);

   // Hang guard, well above the expected run length
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] obs);
      cmp_count++;
      if (obs !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, obs);
      end
   endtask

   // Looks at the current cycle first: the pulse stands one cycle only
   task automatic wait_fetch(input int lim, output logic s);
      s = 1'b0;
      for (int i = 0; i < lim; i++)
      begin
         if (fetch === 1'b1)
         begin
            s = 1'b1;
            break;
         end
         @(negedge mclk);
      end
   endtask

   task automatic finish_load();
      ld_done = 1'b1;
      tick(1);
      ld_done = 1'b0;
      tick(1);
      chk("user_mode", 1'b1, umode);
   endtask

   task automatic go_app(input logic [23:0] a);
      app_addr = a;
      core_req = 1'b1;
      tick(1);
      core_req = 1'b0;
      chk("fetch_start", 1'b1, fetch);
      chk("start_addr", a, addr);
      chk("factory_active", 1'b0, fact);
      chk("cause", `CDRU_CAUSE_CORE, cause);
      tick(1);
      chk("fetch_one_cycle", 1'b0, fetch);
      finish_load();
   endtask

   // Raise one fallback trigger while an application image runs
   task automatic revert(input int t);
      stat_n   = (t != 1);
      crc      = (t == 2);
      wd_en    = (t == 3);
      core_req = (t == 4);
      ext_n    = (t != 5);
      tick(t == 5 ? 6 : 1);
      core_req = 1'b0;
      ext_n    = 1'b1;
      wait_fetch(150, seen);
      chk("revert_fetch", 1'b1, seen);
      chk("revert_addr", `CDRU_FACTORY_ADDR, addr);
      chk("factory_active", 1'b1, fact);
      chk("cause", t[2:0], cause);
      stat_n = 1'b1;
      crc    = 1'b0;
      wd_en  = 1'b0;
      tick(8);
      finish_load();
   endtask

   task automatic chk_stream(input logic [7:0] exp[$]);
      for (int i = 0; i < 400 && got.size() < exp.size(); i++)
         tick(1);
      tick(10);
      chk("stream_len", exp.size(), got.size());
      foreach (exp[i])
         if (i < got.size())
            chk("cell_data", exp[i], got[i]);
      got.delete();
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {rst_n, crc, core_req, wd_en, wd_kick, ld_done, stall} = 7'h00;
      {stat_n, ext_n, rdy_lvl, comp} = 4'hf;
      app_addr = 24'h000000;
      scheme   = `CDRU_SCHEME_AS;
      tick(5);
      chk("factory_active", 1'b1, fact);
      chk("fetch_in_reset", 1'b0, fetch);
      chk("cause_in_reset", `CDRU_CAUSE_NONE, cause);
      rst_n = 1'b1;
      tick(1);
      chk("power_up_fetch", 1'b1, fetch);
      chk("power_up_addr", `CDRU_FACTORY_ADDR, addr);
      core_req = 1'b1;
      tick(1);
      core_req = 1'b0;
      wait_fetch(10, seen);
      chk("early_request", 1'b0, seen);
      finish_load();
      // Scheme, ratio and fallback table
      foreach (rows[k])
      begin
         scheme = rows[k].sch;
         comp   = rows[k].cmp;
         tick(4);
         chk("remote_ok", rows[k].ok, rok);
         chk("clocks_per_word", rows[k].cpw, cpw);
         if (rows[k].trig == 0)
         begin
            core_req = 1'b1;
            tick(1);
            core_req = 1'b0;
            wait_fetch(20, seen);
            chk("refused_fetch", 1'b0, seen);
         end
         else
         begin
            go_app({8'(k + 1), 16'h0000});
            revert(rows[k].trig);
         end
      end
      // Compressed stream, run split across frames, FIFO held full
      scheme  = `CDRU_SCHEME_AS;
      comp    = 1'b1;
      rdy_lvl = 1'b0;
      tick(4);
      // Streams flow only while an image loads
      core_req = 1'b1;
      tick(1);
      core_req = 1'b0;
      chk("stream_fetch", 1'b1, fetch);
      cdru_link_host_inst.send_frame('{8'h83, 8'h5a, 8'h11, 8'h84});
      tick(20);
      cdru_link_host_inst.send_frame('{8'h0f});
      tick(20);
      cdru_link_host_inst.send_frame('{8'h77});
      tick(40);
      chk("full_valid", 1'b1, cvalid);
      stall = 1'b1;
      chk_stream('{8'h5a, 8'h5a, 8'h5a, 8'h11, 8'h0f, 8'h0f, 8'h0f, 8'h0f, 8'h77});
      // Longest run with stalls
      cdru_link_host_inst.send_frame('{8'h8f, 8'h3c});
      chk_stream('{15{8'h3c}});
      // Per-device plain setting, and boundary-scan stays plain
      comp = 1'b0;
      tick(4);
      cdru_link_host_inst.send_frame('{8'h83, 8'h22});
      chk_stream('{8'h83, 8'h22});
      scheme = `CDRU_SCHEME_JTAG;
      comp   = 1'b1;
      tick(4);
      cdru_link_host_inst.send_frame('{8'h85, 8'h33});
      chk_stream('{8'h85, 8'h33});
      stall = 1'b0;
      tick(10);
      chk("drained", 1'b0, cvalid);
      // Reset again while an application runs
      scheme = `CDRU_SCHEME_AS;
      tick(4);
      finish_load();
      revert(4);
      go_app(24'h200000);
      rst_n = 1'b0;
      tick(2);
      chk("factory_active", 1'b1, fact);
      chk("reset_addr", `CDRU_FACTORY_ADDR, addr);
      rst_n = 1'b1;
      tick(1);
      chk("power_up_fetch", 1'b1, fetch);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
